// File: rtl/sample_queue_regs.vh
`ifndef SAMPLE_QUEUE_REGS_VH
`define SAMPLE_QUEUE_REGS_VH
`define ADDR_THRESHOLD_LIMITS 6'h3c
`define ADDR_SAMPLE_READOUT   6'h3d
`define THRESHOLD_RESET       24'hfff000
`define UPPER_MSB             23
`define UPPER_LSB             12
`define LOWER_MSB             11
`define LOWER_LSB             0
`define READOUT_RESET         16'h0000
`define SPI_READ_BIT          7
`define SPI_CMD_BITS          8
`define QUEUE_DEPTH           256
`define QUEUE_ADDR_BITS       8
`endif

// File: rtl/pin_sync.v
`timescale 1ns/1ns
// ------------------------------------------------------------
// Three-stage pin synchroniser; change counts when stages 2,3 agree
// ------------------------------------------------------------
module pin_sync (
  input  wire MCLK,
  input  wire RESET,
  input  wire din,
  input  wire init,
  output reg  dout
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge MCLK) begin
    // Stages start at the pin's idle level so no false edge follows reset
    if (RESET) begin
      s1_r <= init;
      s2_r <= init;
      s3_r <= init;
      dout <= init;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule

// File: rtl/sample_store.v
`timescale 1ns/1ns
`include "sample_queue_regs.vh"
// ------------------------------------------------------------
// Sample storage ring; push and pop in arrival order
// ------------------------------------------------------------
module sample_store #(
  parameter DW = 16,
  parameter AW = `QUEUE_ADDR_BITS
) (
  input  wire          MCLK,
  input  wire          RESET,
  input  wire          flush,
  input  wire          push,
  input  wire [DW-1:0] push_data,
  input  wire          pop,
  output wire [DW-1:0] head_data,
  output wire [AW:0]   count
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  reg [AW-1:0] wr_r;
  reg [AW-1:0] rd_r;
  reg [AW:0]   cnt_r;
  wire         full    = cnt_r[AW];
  wire         do_pop  = pop && (cnt_r != {(AW+1){1'b0}});
  wire         do_push = push && !full;
  assign head_data = mem[rd_r];
  assign count     = cnt_r;
  always @(posedge MCLK) begin
    if (do_push) begin
      mem[wr_r] <= push_data;
    end
  end
  always @(posedge MCLK) begin
    if (RESET || flush) begin
      wr_r  <= {AW{1'b0}};
      rd_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (do_pop) begin
        rd_r <= rd_r + 1'b1;
      end
      if (do_push && !do_pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// File: rtl/sample_queue_readout.v
`timescale 1ns/1ns
`include "sample_queue_regs.vh"
// ------------------------------------------------------------
// Sample queue tail: empty flag, threshold check, serial readout
// ------------------------------------------------------------
module sample_queue_readout #(
  parameter DW = 16,
  parameter AW = `QUEUE_ADDR_BITS,
  parameter CH = 16
) (
  input  wire          MCLK,
  input  wire          RESET,
  input  wire          SCLK,
  input  wire          CS_N,
  input  wire          MOSI,
  output reg           MISO,
  output reg           MISO_OE_N,
  input  wire          QUEUE_ENABLE,
  input  wire          QUEUE_CLEAR,
  input  wire          SAMPLE_VALID,
  input  wire [DW-1:0] SAMPLE_DATA,
  input  wire [3:0]    SAMPLE_CHANNEL,
  input  wire [CH-1:0] CHANNEL_LIMIT_CHECK_ENABLE,
  output reg           QUEUE_EMPTY,
  output reg           QUEUE_EMPTY_IRQ,
  output reg           UPPER_LIMIT_HIT,
  output reg           UPPER_LIMIT_IRQ,
  output reg           LOWER_LIMIT_HIT,
  output reg           LOWER_LIMIT_IRQ,
  output reg [23:0]    THRESHOLD_LIMITS
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  wire sclk_s;
  wire cs_n_s;
  wire mosi_s;
  pin_sync u_sclk (.MCLK(MCLK), .RESET(RESET), .din(SCLK), .init(1'b0), .dout(sclk_s));
  pin_sync u_csn  (.MCLK(MCLK), .RESET(RESET), .din(CS_N), .init(1'b1), .dout(cs_n_s));
  pin_sync u_mosi (.MCLK(MCLK), .RESET(RESET), .din(MOSI), .init(1'b0), .dout(mosi_s));

  // ------------------------------------------------------------
  // Serial clock edges
  // ------------------------------------------------------------
  reg  sclk_d_r;
  wire sclk_rise = sclk_s && !sclk_d_r;
  wire sclk_fall = !sclk_s && sclk_d_r;
  // Synced chip select restarts the frame; it starts high so reset never opens one
  wire frame     = !cs_n_s;

  always @(posedge MCLK) begin
    if (RESET) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
    end
  end

  // ------------------------------------------------------------
  // Serial frame: 8-bit command then data, MSB first, mode 0
  // ------------------------------------------------------------
  localparam ST_CMD  = 2'd0;
  localparam ST_DATA = 2'd1;
  localparam ST_DONE = 2'd2;

  reg  [1:0]    st_r;
  reg  [1:0]    st_nxt;
  reg  [5:0]    bitcnt_r;
  reg  [5:0]    bitcnt_nxt;
  reg  [7:0]    cmd_r;
  reg  [7:0]    cmd_nxt;
  reg  [23:0]   shin_r;
  reg  [23:0]   shin_nxt;
  reg  [23:0]   shout_r;
  reg  [23:0]   shout_nxt;
  reg           pop_r;
  reg           pop_nxt;
  reg  [23:0]   limits_r;
  reg  [23:0]   limits_nxt;
  reg           miso_nxt;
  reg           miso_oe_n_nxt;

  wire [DW-1:0] head_data;
  wire [AW:0]   count;
  wire          is_read   = cmd_r[`SPI_READ_BIT];
  wire [5:0]    cmd_addr  = cmd_r[5:0];
  wire [7:0]    cmd_full  = {cmd_r[6:0], mosi_s};
  wire [23:0]   shin_full = {shin_r[22:0], mosi_s};

  function is_limits_addr;
    input [5:0] a;
    begin
      is_limits_addr = (a == `ADDR_THRESHOLD_LIMITS);
    end
  endfunction

  function is_readout_addr;
    input [5:0] a;
    begin
      is_readout_addr = (a == `ADDR_SAMPLE_READOUT);
    end
  endfunction

  // Unknown addresses still take one data byte so the frame stays aligned
  function [5:0] data_len;
    input [5:0] a;
    begin
      if (is_limits_addr(a)) begin
        data_len = 6'd24;
      end else if (is_readout_addr(a)) begin
        data_len = 6'd16;
      end else begin
        data_len = 6'd8;
      end
    end
  endfunction

  // Read image of a register, MSB aligned to bit 23
  function [23:0] read_image;
    input [5:0]    a;
    input [23:0]   lim;
    input [DW-1:0] head;
    begin
      if (is_limits_addr(a)) begin
        read_image = lim;
      end else if (is_readout_addr(a)) begin
        read_image = {head, 8'h00};
      end else begin
        read_image = 24'h000000;
      end
    end
  endfunction

  always @* begin
    st_nxt        = st_r;
    bitcnt_nxt    = bitcnt_r;
    cmd_nxt       = cmd_r;
    shin_nxt      = shin_r;
    shout_nxt     = shout_r;
    pop_nxt       = 1'b0;
    limits_nxt    = limits_r;
    miso_nxt      = MISO;
    miso_oe_n_nxt = !(frame && st_r == ST_DATA && is_read);
    if (!frame) begin
      st_nxt     = ST_CMD;
      bitcnt_nxt = 6'd0;
    end else if (sclk_rise) begin
      case (st_r)
        ST_CMD: begin
          cmd_nxt    = cmd_full;
          bitcnt_nxt = bitcnt_r + 6'd1;
          if (bitcnt_r == `SPI_CMD_BITS - 1) begin
            st_nxt     = ST_DATA;
            bitcnt_nxt = 6'd0;
            // Head is latched here, so a push during the frame cannot tear the word
            shout_nxt  = read_image(cmd_full[5:0], limits_r, head_data);
          end
        end
        ST_DATA: begin
          shin_nxt   = shin_full;
          bitcnt_nxt = bitcnt_r + 6'd1;
          if (bitcnt_r == data_len(cmd_addr) - 6'd1) begin
            st_nxt = ST_DONE;
            if (!is_read && is_limits_addr(cmd_addr)) begin
              limits_nxt = shin_full;
            end
            if (is_read && is_readout_addr(cmd_addr)) begin
              pop_nxt = 1'b1;
            end
          end
        end
        default: begin
          st_nxt = ST_DONE;
        end
      endcase
    end else if (sclk_fall && st_r == ST_DATA) begin
      miso_nxt  = shout_r[23];
      shout_nxt = {shout_r[22:0], 1'b0};
    end
  end

  always @(posedge MCLK) begin
    if (RESET) begin
      st_r      <= ST_CMD;
      bitcnt_r  <= 6'd0;
      cmd_r     <= 8'h00;
      shin_r    <= 24'h000000;
      shout_r   <= 24'h000000;
      pop_r     <= 1'b0;
      limits_r  <= `THRESHOLD_RESET;
      MISO      <= 1'b0;
      MISO_OE_N <= 1'b1;
    end else begin
      st_r      <= st_nxt;
      bitcnt_r  <= bitcnt_nxt;
      cmd_r     <= cmd_nxt;
      shin_r    <= shin_nxt;
      shout_r   <= shout_nxt;
      pop_r     <= pop_nxt;
      limits_r  <= limits_nxt;
      MISO      <= miso_nxt;
      MISO_OE_N <= miso_oe_n_nxt;
    end
  end

  // ------------------------------------------------------------
  // Storage and status
  // ------------------------------------------------------------
  wire flush = QUEUE_CLEAR || !QUEUE_ENABLE;
  wire push  = SAMPLE_VALID && QUEUE_ENABLE;

  sample_store #(.DW(DW), .AW(AW)) u_store (
    .MCLK      (MCLK),
    .RESET     (RESET),
    .flush     (flush),
    .push      (push),
    .push_data (SAMPLE_DATA),
    .pop       (pop_r),
    .head_data (head_data),
    .count     (count)
  );

  // Compared part of a sample: its top 12 bits
  function [11:0] sample_key;
    input [DW-1:0] d;
    begin
      sample_key = d[DW-1:DW-12];
    end
  endfunction

  // Only a sample that really lands in the store is compared
  wire stored      = push && !QUEUE_CLEAR && !count[AW];
  wire chk         = stored && CHANNEL_LIMIT_CHECK_ENABLE[SAMPLE_CHANNEL];
  // Limits are compared at push time only; host must flush after changing them
  wire upper_match = chk && (sample_key(SAMPLE_DATA) >= limits_r[`UPPER_MSB:`UPPER_LSB]);
  wire lower_match = chk && (sample_key(SAMPLE_DATA) <= limits_r[`LOWER_MSB:`LOWER_LSB]);

  reg empty_nxt;
  reg upper_hit_nxt;
  reg lower_hit_nxt;

  // Count is registered, so empty after pop or QUEUE_CLEAR is seen one cycle later; a disable sets it directly
  always @* begin
    empty_nxt     = (count == {(AW+1){1'b0}}) || !QUEUE_ENABLE;
    upper_hit_nxt = UPPER_LIMIT_HIT;
    lower_hit_nxt = LOWER_LIMIT_HIT;
    // A new hit wins over the emptying clear
    if (upper_match) begin
      upper_hit_nxt = 1'b1;
    end else if (empty_nxt) begin
      upper_hit_nxt = 1'b0;
    end
    if (lower_match) begin
      lower_hit_nxt = 1'b1;
    end else if (empty_nxt) begin
      lower_hit_nxt = 1'b0;
    end
  end

  always @(posedge MCLK) begin
    if (RESET) begin
      QUEUE_EMPTY      <= 1'b1;
      QUEUE_EMPTY_IRQ  <= 1'b1;
      UPPER_LIMIT_HIT  <= 1'b0;
      UPPER_LIMIT_IRQ  <= 1'b0;
      LOWER_LIMIT_HIT  <= 1'b0;
      LOWER_LIMIT_IRQ  <= 1'b0;
      THRESHOLD_LIMITS <= `THRESHOLD_RESET;
    end else begin
      QUEUE_EMPTY      <= empty_nxt;
      QUEUE_EMPTY_IRQ  <= empty_nxt;
      UPPER_LIMIT_HIT  <= upper_hit_nxt;
      UPPER_LIMIT_IRQ  <= upper_hit_nxt;
      LOWER_LIMIT_HIT  <= lower_hit_nxt;
      LOWER_LIMIT_IRQ  <= lower_hit_nxt;
      THRESHOLD_LIMITS <= limits_r;
    end
  end
endmodule

// File: testbench/sample_queue_readout_sva.sv
`timescale 1ns/1ns
// ------------------------------
// Queue tail port checks
// ------------------------------
module queue_readout_checker #(
  parameter DW = 16,
  parameter CH = 16
) (
  input wire          MCLK,
  input wire          RESET,
  input wire          QUEUE_ENABLE,
  input wire          QUEUE_CLEAR,
  input wire          SAMPLE_VALID,
  input wire [DW-1:0] SAMPLE_DATA,
  input wire [3:0]    SAMPLE_CHANNEL,
  input wire [CH-1:0] CHANNEL_LIMIT_CHECK_ENABLE,
  input wire          QUEUE_EMPTY,
  input wire          QUEUE_EMPTY_IRQ,
  input wire          UPPER_LIMIT_HIT,
  input wire          UPPER_LIMIT_IRQ,
  input wire          LOWER_LIMIT_HIT,
  input wire          LOWER_LIMIT_IRQ,
  input wire [23:0]   THRESHOLD_LIMITS
);
  // Pushes while enabled and not cleared are checked, even into a full store, which the design does not compare
  wire chk = SAMPLE_VALID && QUEUE_ENABLE && !QUEUE_CLEAR && CHANNEL_LIMIT_CHECK_ENABLE[SAMPLE_CHANNEL];
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  AST_RESET_STATE: assert property ($fell(RESET) |-> QUEUE_EMPTY && THRESHOLD_LIMITS == 24'hfff000)
    else $error("bad state after reset");
  AST_EMPTY_IRQ: assert property (QUEUE_EMPTY_IRQ == QUEUE_EMPTY)
    else $error("empty irq differs");
  AST_DISABLED: assert property (!QUEUE_ENABLE [*3] |-> QUEUE_EMPTY)
    else $error("disabled queue not empty");
  AST_CLEARED: assert property (QUEUE_CLEAR [*3] |-> QUEUE_EMPTY)
    else $error("cleared queue not empty");
  AST_FILLED: assert property (SAMPLE_VALID && QUEUE_ENABLE && !QUEUE_CLEAR |-> ##[1:3] !QUEUE_EMPTY)
    else $error("empty after push");
  AST_UPPER: assert property (chk && SAMPLE_DATA[DW-1:DW-12] >= THRESHOLD_LIMITS[23:12] |-> ##[1:3] UPPER_LIMIT_HIT)
    else $error("upper hit missed");
  AST_LOWER: assert property (chk && SAMPLE_DATA[DW-1:DW-12] <= THRESHOLD_LIMITS[11:0] |-> ##[1:3] LOWER_LIMIT_HIT)
    else $error("lower hit missed");
  AST_HITS_CLEAR: assert property ($rose(QUEUE_EMPTY) |-> ##[0:2] !UPPER_LIMIT_HIT && !LOWER_LIMIT_HIT)
    else $error("hits kept when empty");
  AST_HIT_IRQS: assert property (UPPER_LIMIT_IRQ == UPPER_LIMIT_HIT && LOWER_LIMIT_IRQ == LOWER_LIMIT_HIT)
    else $error("hit irq differs");
endmodule

bind sample_queue_readout queue_readout_checker #(.DW(DW), .CH(CH)) u_chk (
  .MCLK(MCLK), .RESET(RESET), .QUEUE_ENABLE(QUEUE_ENABLE), .QUEUE_CLEAR(QUEUE_CLEAR),
  .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_DATA(SAMPLE_DATA), .SAMPLE_CHANNEL(SAMPLE_CHANNEL),
  .CHANNEL_LIMIT_CHECK_ENABLE(CHANNEL_LIMIT_CHECK_ENABLE), .QUEUE_EMPTY(QUEUE_EMPTY),
  .QUEUE_EMPTY_IRQ(QUEUE_EMPTY_IRQ), .UPPER_LIMIT_HIT(UPPER_LIMIT_HIT), .UPPER_LIMIT_IRQ(UPPER_LIMIT_IRQ),
  .LOWER_LIMIT_HIT(LOWER_LIMIT_HIT), .LOWER_LIMIT_IRQ(LOWER_LIMIT_IRQ), .THRESHOLD_LIMITS(THRESHOLD_LIMITS));

// File: testbench/spi_host_model.sv
`timescale 1ns/1ns
// ------------------------------
// Serial host, mode 0, 160 ns bit
// ------------------------------
module spi_host_model (
  input  wire MCLK,
  output reg  SCLK,
  output reg  CS_N,
  output reg  MOSI,
  input  wire MISO
);
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    MOSI = 1'b0;
  end
  // Command then n data bits, MSB first; SCLK idles low between frames
  task automatic frame(input [7:0] cmd, input [23:0] d, input integer n, output [23:0] q);
    reg [31:0] sh;
    integer    i;
    sh = {cmd, d << (24 - n)};
    q = 24'h000000;
    @(negedge MCLK);
    CS_N = 1'b0;
    for (i = 0; i < 8 + n; i = i + 1) begin
      MOSI = sh[31 - i];
      repeat (8) @(negedge MCLK);
      SCLK = 1'b1;
      if (i >= 8) q = {q[22:0], MISO};
      repeat (8) @(negedge MCLK);
      SCLK = 1'b0;
    end
    repeat (8) @(negedge MCLK);
    CS_N = 1'b1;
    // Released data line must not look like valid data
    MOSI = ~MOSI;
    repeat (8) @(negedge MCLK);
  endtask
endmodule

// File: testbench/sample_queue_readout_tb_top.sv
`timescale 1ns/1ns
module sample_queue_readout_tb_top;
  reg         MCLK, RESET, QUEUE_ENABLE, QUEUE_CLEAR, SAMPLE_VALID;
  reg  [15:0] SAMPLE_DATA, CHANNEL_LIMIT_CHECK_ENABLE;
  reg  [3:0]  SAMPLE_CHANNEL;
  wire        SCLK, CS_N, MOSI, MISO, MISO_OE_N, QUEUE_EMPTY, UPPER_LIMIT_HIT, LOWER_LIMIT_HIT;
  wire [23:0] THRESHOLD_LIMITS;
  wire [23:0] flags = {21'h000000, QUEUE_EMPTY, UPPER_LIMIT_HIT, LOWER_LIMIT_HIT};
  reg  [23:0] rd;
  reg  [15:0] sent[$];
  integer     failures, cmp_count, cyc, i, oe_cnt;

  sample_queue_readout u_dut (.MCLK(MCLK), .RESET(RESET), .SCLK(SCLK), .CS_N(CS_N), .MOSI(MOSI),
    .MISO(MISO), .MISO_OE_N(MISO_OE_N), .QUEUE_ENABLE(QUEUE_ENABLE), .QUEUE_CLEAR(QUEUE_CLEAR),
    .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_DATA(SAMPLE_DATA), .SAMPLE_CHANNEL(SAMPLE_CHANNEL),
    .CHANNEL_LIMIT_CHECK_ENABLE(CHANNEL_LIMIT_CHECK_ENABLE), .QUEUE_EMPTY(QUEUE_EMPTY),
    .QUEUE_EMPTY_IRQ(), .UPPER_LIMIT_HIT(UPPER_LIMIT_HIT), .UPPER_LIMIT_IRQ(),
    .LOWER_LIMIT_HIT(LOWER_LIMIT_HIT), .LOWER_LIMIT_IRQ(), .THRESHOLD_LIMITS(THRESHOLD_LIMITS));
  spi_host_model u_host (.MCLK(MCLK), .SCLK(SCLK), .CS_N(CS_N), .MOSI(MOSI), .MISO(MISO));

  task chk(input [23:0] got, input [23:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task push(input [15:0] d, input [3:0] c);
    @(negedge MCLK);
    SAMPLE_VALID = 1'b1;
    SAMPLE_DATA = d;
    SAMPLE_CHANNEL = c;
    sent.push_back(d);
    @(negedge MCLK);
    SAMPLE_VALID = 1'b0;
    repeat (4) @(negedge MCLK);
  endtask
  task flush;
    QUEUE_CLEAR = 1'b1;
    repeat (3) @(negedge MCLK);
    QUEUE_CLEAR = 1'b0;
    sent.delete();
    repeat (4) @(negedge MCLK);
  endtask
  task tally_and_finish;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task t_reset;
    chk(flags, 24'h000004);
    chk({23'h000000, MISO_OE_N}, 24'h000001);
    i = oe_cnt;
    u_host.frame(8'hbc, 24'h000000, 24, rd);
    chk(rd, 24'hfff000);
    // Data line is driven for exactly the 24 data bits of 16 MCLK each
    chk({23'h000000, ((oe_cnt - i) == 384)}, 24'h000001);
    $display("t_reset done");
  endtask
  task t_limits;
    i = oe_cnt;
    u_host.frame(8'h3c, 24'h800100, 24, rd);
    chk({23'h000000, (oe_cnt == i)}, 24'h000001);
    u_host.frame(8'h10, 24'h0000a5, 8, rd);
    u_host.frame(8'h3d, 24'h00ffff, 16, rd);
    u_host.frame(8'hbc, 24'h000000, 24, rd);
    chk(rd, 24'h800100);
    chk(THRESHOLD_LIMITS, 24'h800100);
    flush;
    $display("t_limits done");
  endtask
  task t_stream;
    CHANNEL_LIMIT_CHECK_ENABLE = 16'h0004;
    push(16'h7ff0, 4'h2);
    push(16'h1010, 4'h2);
    push(16'h0000, 4'h3);
    chk(flags, 24'h000000);
    push(16'h8000, 4'h2);
    chk(flags, 24'h000002);
    push(16'h1000, 4'h2);
    chk(flags, 24'h000003);
    for (i = 0; i < 5; i = i + 1) begin
      u_host.frame(8'hbd, 24'h000000, 16, rd);
      chk(rd, {8'h00, sent.pop_front()});
    end
    chk(flags, 24'h000004);
    $display("t_stream done");
  endtask
  task t_clear;
    push(16'h1234, 4'h0);
    flush;
    chk(flags, 24'h000004);
    push(16'h1234, 4'h0);
    QUEUE_ENABLE = 1'b0;
    repeat (4) @(negedge MCLK);
    chk(flags, 24'h000004);
    push(16'h4321, 4'h0);
    chk(flags, 24'h000004);
    QUEUE_ENABLE = 1'b1;
    $display("t_clear done");
  endtask

  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  // Longest path is about 4400 cycles of frames
  always @(posedge MCLK) begin
    cyc = cyc + 1;
    if (MISO_OE_N === 1'b0) oe_cnt = oe_cnt + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      tally_and_finish;
    end
  end
  initial begin
    failures = 0;
    cmp_count = 0;
    cyc = 0;
    oe_cnt = 0;
    RESET = 1'b1;
    QUEUE_ENABLE = 1'b1;
    QUEUE_CLEAR = 1'b0;
    SAMPLE_VALID = 1'b0;
    SAMPLE_DATA = 16'h0000;
    SAMPLE_CHANNEL = 4'h0;
    CHANNEL_LIMIT_CHECK_ENABLE = 16'h0000;
    repeat (20) @(negedge MCLK);
    RESET = 1'b0;
    repeat (8) @(negedge MCLK);
    t_reset;
    t_limits;
    t_stream;
    t_clear;
    tally_and_finish;
  end
endmodule
